/* design/uhtc_channel.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "uhtc_params.svh"
module uhtc_channel (
  input  logic        clk,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  input  logic [3:0]  pstrb,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        eng_done,
  input  logic        eng_ack,
  input  logic        eng_nak,
  input  logic        eng_stall,
  input  logic        eng_timeout,
  input  logic        eng_crc_err,
  input  logic        eng_stuff_err,
  input  logic        eng_pid_err,
  input  logic        eng_toggle_err,
  input  logic [9:0]  eng_rx_bytes,
  output logic        tok_req,
  output logic        tok_in,
  output logic [1:0]  tok_kind,
  output logic [1:0]  tok_speed,
  output logic        tok_toggle,
  output logic [9:0]  tok_len
);
  uhtc_pkg::uhtc_st_t q;
  uhtc_pkg::uhtc_st_t d;

  logic [9:0]  idx;
  logic        hit;
  logic        acc;
  logic        wr;
  logic        busy;
  logic        done;
  logic        err;
  logic        is_in;
  logic [7:0]  rdata;
  logic [4:0]  target;
  logic [9:0]  nbytes;
  logic [31:0] rem_new;
  logic [4:0]  ackn_new;
  logic [9:0]  first_len;

  assign idx    = paddr[11:2];
  assign acc    = psel && penable && q.pready;
  assign wr     = acc && pwrite && pstrb[0] && hit;
  assign busy   = (q.state == uhtc_pkg::S_WAIT);
  assign done   = busy && eng_done;
  assign is_in  = (q.token_kind == `UHTC_TID_IN);
  // ==================================================================
  // Packet outcome
  assign err = eng_timeout || eng_crc_err || eng_stuff_err
            || eng_pid_err || eng_toggle_err;
  assign target   = (q.ackc == 4'h0) ? `UHTC_ACK_FULL : {1'b0, q.ackc};
  assign ackn_new = q.ackn + 5'h01;
  assign nbytes   = is_in ? eng_rx_bytes : q.len;
  assign rem_new  = (q.rem > {22'h0, nbytes}) ? q.rem - {22'h0, nbytes} : 32'h0;
  // A partial last packet is sent short; unbounded mode sends full packets unless a zero-length packet is pending.
  assign first_len = q.zlp_pend ? 10'h000
                   : (q.free || q.rem > {22'h0, q.mps}) ? q.mps
                   : q.rem[9:0];

  always_comb
  begin
    unique case (1'b1)
      idx == `UHTC_IDX_CFG0:   rdata = {q.ackc, q.spd, q.tog, q.go | busy};
      idx == `UHTC_IDX_CFG1:   rdata = {q.token_kind, q.kind, q.azl, 2'h0, q.free};
      idx == `UHTC_IDX_MPH:    rdata = {6'h00, q.mps[9:8]};
      idx == `UHTC_IDX_MPL:    rdata = q.mps[7:0];
      idx == `UHTC_IDX_TS_HH:  rdata = q.rem[31:24];
      idx == `UHTC_IDX_TS_HL:  rdata = q.snap[23:16];
      idx == `UHTC_IDX_TS_LH:  rdata = q.snap[15:8];
      idx == `UHTC_IDX_TS_LL:  rdata = q.snap[7:0];
      idx == `UHTC_IDX_EVT:    rdata = {5'h00, q.flags};
      idx == `UHTC_IDX_CODE:   rdata = {1'b0, q.code, 4'h0};
      default:                 rdata = 8'h00;
    endcase
  end

  always_comb
  begin
    hit = (idx >= `UHTC_IDX_CFG0 && idx <= `UHTC_IDX_TS_LL)
       || idx == `UHTC_IDX_EVT || idx == `UHTC_IDX_CODE;
  end

  // ==================================================================
  // Next state
  always_comb
  begin
    d         = q;
    d.req     = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    if (psel && !penable)
    begin
      d.pready  = 1'b1;
      d.pslverr = !hit;
      d.prdata  = {24'h000000, rdata};
    end
    // The snapshot keeps lower bytes coherent across four byte reads.
    if (acc && !pwrite && idx == `UHTC_IDX_TS_HH)
    begin
      d.snap = q.rem[23:0];
    end
    if (wr)
    begin
      unique case (1'b1)
        idx == `UHTC_IDX_CFG0:
        begin
          d.ackc = pwdata[7:4];
          d.spd  = pwdata[3:2];
          d.tog  = pwdata[1];
          d.go   = pwdata[0];
        end
        idx == `UHTC_IDX_CFG1:
        begin
          d.token_kind  = pwdata[7:6];
          d.kind = pwdata[5:4];
          d.azl  = pwdata[3];
          d.free = pwdata[0];
        end
        idx == `UHTC_IDX_MPH:    d.mps[9:8]   = pwdata[1:0];
        idx == `UHTC_IDX_MPL:    d.mps[7:0]   = pwdata[7:0];
        idx == `UHTC_IDX_TS_HH:  d.rem[31:24] = pwdata[7:0];
        idx == `UHTC_IDX_TS_HL:  d.rem[23:16] = pwdata[7:0];
        idx == `UHTC_IDX_TS_LH:  d.rem[15:8]  = pwdata[7:0];
        idx == `UHTC_IDX_TS_LL:  d.rem[7:0]   = pwdata[7:0];
        idx == `UHTC_IDX_EVT:    d.flags      = q.flags & ~pwdata[2:0];
        default:                 d.code       = q.code;
      endcase
    end
    unique case (q.state)
      uhtc_pkg::S_IDLE:
      begin
        if (q.go && !q.free && is_in && q.rem == 32'h0)
        begin
          // Nothing left to receive, so the transfer is already complete.
          d.go                 = 1'b0;
          d.code               = `UHTC_CODE_OK;
          d.flags[`UHTC_EVT_CMP] = 1'b1;
        end
        else if (q.go)
        begin
          d.req   = 1'b1;
          d.len   = first_len;
          d.state = uhtc_pkg::S_WAIT;
        end
      end
      uhtc_pkg::S_WAIT:
      begin
        if (eng_done)
        begin
          d.state = uhtc_pkg::S_IDLE;
          if (err)
          begin
            d.code                = `UHTC_CODE_RETRY;
            d.flags[`UHTC_EVT_CC] = 1'b1;
            d.go                  = 1'b0;
          end
          else if (eng_stall)
          begin
            d.code                = `UHTC_CODE_STALL;
            d.flags[`UHTC_EVT_CC] = 1'b1;
            d.go                  = 1'b0;
          end
          else if (is_in && eng_rx_bytes > q.mps)
          begin
            d.code                = `UHTC_CODE_OVR;
            d.flags[`UHTC_EVT_CC] = 1'b1;
            d.go                  = 1'b0;
          end
          else if (eng_ack)
          begin
            d.tog      = !q.tog;
            d.zlp_pend = 1'b0;
            d.ackn     = (ackn_new == target) ? 5'h00 : ackn_new;
            if (ackn_new == target)
            begin
              d.flags[`UHTC_EVT_ACK] = 1'b1;
            end
            if (!q.free)
            begin
              d.rem = rem_new;
            end
            if (is_in && !q.free && nbytes < q.mps && rem_new != 32'h0)
            begin
              d.code                = `UHTC_CODE_UND;
              d.flags[`UHTC_EVT_CC] = 1'b1;
              d.go                  = 1'b0;
            end
            else if (!q.free && rem_new == 32'h0 && !is_in && q.azl
                     && q.len == q.mps && q.len != 10'h000)
            begin
              d.zlp_pend = 1'b1;
              // A stop written in the closing cycle itself must still be reported.
              if (!d.go)
              begin
                d.flags[`UHTC_EVT_CC] = 1'b1;
                d.code                = `UHTC_CODE_OK;
              end
            end
            else if (!q.free && rem_new == 32'h0)
            begin
              d.code                 = `UHTC_CODE_OK;
              d.flags[`UHTC_EVT_CMP] = 1'b1;
              d.go                   = 1'b0;
            end
            else if (!d.go)
            begin
              d.code                = `UHTC_CODE_OK;
              d.flags[`UHTC_EVT_CC] = 1'b1;
            end
          end
          else if (!d.go)
          begin
            // A stop during NAK retries ends after the NAKed attempt.
            d.code                = `UHTC_CODE_OK;
            d.flags[`UHTC_EVT_CC] = 1'b1;
          end
        end
      end
    endcase
  end

  // ==================================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q          <= '0;
      q.state    <= uhtc_pkg::S_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign tok_req    = q.req;
  assign tok_in     = q.token_kind[1];
  assign tok_kind   = q.kind;
  assign tok_speed  = q.spd;
  assign tok_toggle = q.tog;
  assign tok_len    = q.len;

  // ==================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_req_go;
    tok_req |-> $past(q.go) && busy;
  endproperty
  a_req_go: assert property (p_req_go) else $error("request without go");

  property p_cmp_go;
    $rose(q.flags[`UHTC_EVT_CMP]) |-> !q.go && !busy;
  endproperty
  a_cmp_go: assert property (p_cmp_go) else $error("go still set");

  property p_cc_go;
    $rose(q.flags[`UHTC_EVT_CC]) && q.code != `UHTC_CODE_OK |-> !q.go;
  endproperty
  a_cc_go: assert property (p_cc_go) else $error("go kept on error");

  property p_retry;
    done && err |=> q.code == `UHTC_CODE_RETRY && q.flags[`UHTC_EVT_CC];
  endproperty
  a_retry: assert property (p_retry) else $error("retry not reported");

  property p_code;
    q.code <= `UHTC_CODE_RETRY;
  endproperty
  a_code: assert property (p_code) else $error("reserved code");

  property p_tog;
    done && !err && !eng_stall && !eng_nak && !is_in |=> q.tog != $past(q.tog);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle not advanced");

  property p_len;
    tok_req |-> tok_len <= q.mps;
  endproperty
  a_len: assert property (p_len) else $error("packet too long");

  property p_snap;
    !(acc && !pwrite && idx == `UHTC_IDX_TS_HH) |=> $stable(q.snap);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved");

  property p_ack;
    done && !err && !eng_stall && !eng_nak && !is_in && ackn_new == target
      |=> q.flags[`UHTC_EVT_ACK] && q.ackn == 5'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("ack target missed");
endmodule : uhtc_channel

/* design/uhtc_params.svh */
`ifndef UHTC_PARAMS_SVH
`define UHTC_PARAMS_SVH
// ====================================================================
// Register indices (byte address is four times the index)
`define UHTC_IDX_CFG0   10'h1A0
`define UHTC_IDX_CFG1   10'h1A1
`define UHTC_IDX_MPH    10'h1A2
`define UHTC_IDX_MPL    10'h1A3
`define UHTC_IDX_TS_HH  10'h1A4
`define UHTC_IDX_TS_HL  10'h1A5
`define UHTC_IDX_TS_LH  10'h1A6
`define UHTC_IDX_TS_LL  10'h1A7
`define UHTC_IDX_EVT    10'h1B0
`define UHTC_IDX_CODE   10'h1B1
// ====================================================================
// Field encodings and reset values
`define UHTC_TID_OUT    2'h1
`define UHTC_TID_IN     2'h2
`define UHTC_EVT_ACK    0
`define UHTC_EVT_CMP    1
`define UHTC_EVT_CC     2
`define UHTC_CODE_OK    3'h0
`define UHTC_CODE_STALL 3'h1
`define UHTC_CODE_OVR   3'h2
`define UHTC_CODE_UND   3'h3
`define UHTC_CODE_RETRY 3'h4
`define UHTC_ACK_FULL   5'h10
`define UHTC_RST_REG    8'h00
`endif

/* design/uhtc_pkg.sv */
package uhtc_pkg;
  // ==================================================================
  // Types
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_WAIT = 2'b10
  } uhtc_state_t;

  typedef struct packed {
    uhtc_state_t state;
    logic        go;
    logic        tog;
    logic [3:0]  ackc;
    logic [1:0]  spd;
    logic [1:0]  token_kind;
    logic [1:0]  kind;
    logic        azl;
    logic        free;
    logic [9:0]  mps;
    logic [31:0] rem;
    logic [23:0] snap;
    logic [4:0]  ackn;
    logic [2:0]  flags;
    logic [2:0]  code;
    logic        zlp_pend;
    logic        req;
    logic [9:0]  len;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uhtc_st_t;
endpackage : uhtc_pkg

/* tb/tb.sv */
`timescale 1ns/1ps
`include "uhtc_params.svh"
module tb;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic       wr;
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic       err;
  } uhtc_row_t;

  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        eng_done, tok_req, tok_in, tok_toggle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  eng_q;
  logic [9:0]  eng_rx_bytes, tok_len;
  logic [1:0]  tok_kind, tok_speed;
  logic [2:0]  mode;
  logic [3:0]  dly;
  logic [10:0] seen [$];
  int          errors, check_count, cycles;
  uhtc_row_t   rows [15] = '{
    '{1'h0, `UHTC_IDX_CFG0, 8'h00, 8'h00, 1'h0}, '{1'h0, `UHTC_IDX_CFG1, 8'h00, 8'h00, 1'h0},
    '{1'h0, `UHTC_IDX_MPH, 8'h00, 8'h00, 1'h0}, '{1'h0, `UHTC_IDX_MPL, 8'h00, 8'h00, 1'h0},
    '{1'h0, `UHTC_IDX_TS_HH, 8'h00, 8'h00, 1'h0}, '{1'h0, `UHTC_IDX_TS_LL, 8'h00, 8'h00, 1'h0},
    '{1'h0, `UHTC_IDX_EVT, 8'h00, 8'h00, 1'h0}, '{1'h0, `UHTC_IDX_CODE, 8'h00, 8'h00, 1'h0},
    '{1'h0, 10'h3FF, 8'h00, 8'h00, 1'h1}, '{1'h1, `UHTC_IDX_MPH, 8'h02, 8'h00, 1'h0},
    '{1'h1, `UHTC_IDX_MPL, 8'h40, 8'h00, 1'h0}, '{1'h0, `UHTC_IDX_MPH, 8'h00, 8'h02, 1'h0},
    '{1'h0, `UHTC_IDX_MPL, 8'h00, 8'h40, 1'h0}, '{1'h1, `UHTC_IDX_TS_LL, 8'h21, 8'h00, 1'h0},
    '{1'h0, `UHTC_IDX_TS_HH, 8'h00, 8'h00, 1'h0}};

  always #50 clk = ~clk;

  uhtc_channel DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_done(eng_done), .eng_ack(eng_q[0]), .eng_nak(eng_q[1]),
    .eng_stall(eng_q[2]), .eng_timeout(eng_q[3]), .eng_crc_err(eng_q[4]),
    .eng_stuff_err(eng_q[5]), .eng_pid_err(eng_q[6]), .eng_toggle_err(eng_q[7]),
    .eng_rx_bytes(eng_rx_bytes), .tok_req(tok_req), .tok_in(tok_in), .tok_kind(tok_kind),
    .tok_speed(tok_speed), .tok_toggle(tok_toggle), .tok_len(tok_len));

  uhtc_peer_model peer (.clk(clk), .rst(rst), .tok_req(tok_req), .tok_in(tok_in),
    .tok_len(tok_len), .mode(mode), .dly(dly), .eng_done(eng_done), .eng_q(eng_q),
    .eng_rx_bytes(eng_rx_bytes));

  // ==================================================================
  // Monitor and watchdog
  always @(posedge clk)
  begin
    if (tok_req === 1'h1)
      seen.push_back({tok_toggle, tok_len});
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      end_of_test();
    end
  end

  // ==================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits on pready with no assumed latency; only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rchk

  task automatic run_wait;
    rd = 32'h0;
    while (rd[2:1] === 2'h0) apb(1'h0, `UHTC_IDX_EVT, 8'h00);
  endtask : run_wait

  task automatic setup(input logic [7:0] c1, input logic [7:0] mpl, input logic [7:0] ll);
    apb(1'h1, `UHTC_IDX_CFG1, c1);
    apb(1'h1, `UHTC_IDX_MPH, 8'h00);
    apb(1'h1, `UHTC_IDX_MPL, mpl);
    apb(1'h1, `UHTC_IDX_TS_LL, ll);
    apb(1'h1, `UHTC_IDX_EVT, 8'h07);
    seen.delete();
  endtask : setup

  // A long answer delay keeps the stop write inside an outstanding transaction.
  task automatic stop_mid(input logic [7:0] c0);
    while (seen.size() < 3) @(posedge clk);
    apb(1'h1, `UHTC_IDX_CFG0, c0);
    run_wait();
  endtask : stop_mid

  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // ==================================================================
  // Main sequence
  initial
  begin
    clk = 1'h0; rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h000; pwdata = 32'h0; mode = 3'h0; dly = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].idx, rows[i].wd);
      if (!rows[i].wr)
      begin
        chk(rd, {24'h0, rows[i].exp});
        chk(32'(err), 32'(rows[i].err));
      end
    end
    setup(8'h68, 8'h08, 8'h10);
    apb(1'h1, `UHTC_IDX_CFG0, 8'h27);
    run_wait();
    chk(32'(seen.size()), 32'd3);
    chk(32'(seen[0]), 32'h408);
    chk(32'(seen[1]), 32'h008);
    chk(32'(seen[2]), 32'h400);
    chk(32'({tok_in, tok_kind, tok_speed}), 32'h09);
    rchk(`UHTC_IDX_EVT, 8'h03);
    rchk(`UHTC_IDX_CFG0, 8'h24);
    for (int m = 2; m < 8; m++)
    begin
      mode <= m[2:0];
      dly  <= 4'h3;
      setup(8'hB0, 8'h08, 8'h08);
      apb(1'h1, `UHTC_IDX_CFG0, 8'h0D);
      run_wait();
      rchk(`UHTC_IDX_CODE, (m == 2) ? 8'h10 : 8'h40);
      rchk(`UHTC_IDX_CFG0, 8'h0C);
      chk(32'({tok_in, tok_kind, tok_speed}), 32'h1F);
    end
    mode <= 3'h1;
    dly  <= 4'h8;
    setup(8'h60, 8'h08, 8'h10);
    apb(1'h1, `UHTC_IDX_CFG0, 8'h05);
    rchk(`UHTC_IDX_CFG0, 8'h05);
    stop_mid(8'h04);
    rchk(`UHTC_IDX_EVT, 8'h04);
    rchk(`UHTC_IDX_CODE, 8'h00);
    rchk(`UHTC_IDX_TS_HH, 8'h00);
    rchk(`UHTC_IDX_TS_LL, 8'h10);
    mode <= 3'h0;
    apb(1'h1, `UHTC_IDX_EVT, 8'h07);
    seen.delete();
    apb(1'h1, `UHTC_IDX_CFG0, 8'h05);
    run_wait();
    rchk(`UHTC_IDX_EVT, 8'h02);
    chk(32'(seen.size()), 32'd2);
    setup(8'h60, 8'h08, 8'h00);
    apb(1'h1, `UHTC_IDX_CFG0, 8'h05);
    run_wait();
    chk(32'(seen.size()), 32'd1);
    chk(32'(seen[0][9:0]), 32'h0);
    setup(8'h61, 8'h08, 8'h08);
    apb(1'h1, `UHTC_IDX_CFG0, 8'h05);
    stop_mid(8'h04);
    chk(32'(seen[2][9:0]), 32'h8);
    rchk(`UHTC_IDX_EVT, 8'h04);
    end_of_test();
  end
endmodule : tb

/* tb/uhtc_peer_model.sv */
`timescale 1ns/1ps
// ====================================================================
// Peripheral model behind the packet engine
module uhtc_peer_model (
  input  logic       clk,
  input  logic       rst,
  input  logic       tok_req,
  input  logic       tok_in,
  input  logic [9:0] tok_len,
  input  logic [2:0] mode,
  input  logic [3:0] dly,
  output logic       eng_done,
  output logic [7:0] eng_q,
  output logic [9:0] eng_rx_bytes
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [7:0] junk_q;

  // One transaction outstanding; the answer comes dly+2 cycles after the token.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q   <= 1'h0;
      cnt_q    <= 4'h0;
      eng_done <= 1'h0;
      junk_q   <= 8'h5A;
    end
    else
    begin
      junk_q   <= junk_q + 8'h3B;
      eng_done <= 1'h0;
      if (tok_req)
      begin
        busy_q <= 1'h1;
        cnt_q  <= dly;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        busy_q   <= 1'h0;
        eng_done <= 1'h1;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  // Outside the answer cycle the qualifiers carry a moving pattern, so a design
  // that samples them at the wrong moment sees garbage rather than the last answer.
  assign eng_q        = eng_done ? (8'h01 << mode) : junk_q;
  assign eng_rx_bytes = eng_done ? (tok_in ? tok_len : 10'h000) : {2'h0, junk_q};
endmodule : uhtc_peer_model
